// [fracn_pkg.sv]
// fracn_pkg: constants and carriers shared by the fractional-n ratio mode selector
// assumes a single 50 MHz core clock; no imports anywhere, names are scoped
package fracn_pkg;

  localparam int RATIO_W      = 32;
  localparam int RATIO_INT_W  = 12;
  localparam int RATIO_FRAC_W = 20;

  // ahb register byte offsets
  localparam logic [7:0] OFS_RATIO0 = 8'h00;
  localparam logic [7:0] OFS_RATIO1 = 8'h04;
  localparam logic [7:0] OFS_RATIO2 = 8'h08;
  localparam logic [7:0] OFS_RATIO3 = 8'h0c;
  localparam logic [7:0] OFS_GLOBAL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_N      = 8'h18;
  localparam logic [7:0] OFS_MEAS   = 8'h1c;

  // global word fields
  localparam int GL_BW_LSB   = 0;
  localparam int GL_AUTO_BIT = 4;
  localparam int GL_HYB_BIT  = 5;

  // reset values
  localparam logic [31:0] RATIO_RST  = 32'h0010_0000;
  localparam logic [2:0]  BW_RST     = 3'h0;
  localparam logic [2:0]  BW_WIDE    = 3'h7;

  // timing
  localparam int CLK_MHZ          = 50;
  localparam int REF_LOSS_US      = 100;
  localparam int REF_LOSS_CYC     = REF_LOSS_US * CLK_MHZ;
  localparam int LOCK_TOL         = 16;
  localparam int LOCK_HOLD        = 8;

  typedef enum logic [1:0] {
    ST_STATIC  = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_LOCKED  = 2'b10
  } loop_state_e;

  typedef struct packed {
    logic [2:0] loop_bandwidth_floor;
    logic       auto_select;
    logic       manual_hybrid;
  } global_cfg_s;

endpackage : fracn_pkg

// [fracn_ratio_mode_select.sv]
// fracn_ratio_mode_select: mode-set selection, fractional-n source select and digital loop
// assumes ahb-lite single-word transfers, and that the output and frequency reference clocks
// arrive as asynchronous pins sampled on REF_CLK
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - The synchronised two-bit mode code picks one of four stored sets and its ratio.
// - Global settings hold one value for all modes and ignore the mode pins.
// - N fed to the synthesizer is either the stored static ratio or the loop's dynamic ratio.
// - Hybrid versus static is chosen automatically by reference presence or manually.
// - The loop measures output-to-reference ratio, compares with the target, and forms N.
// - The loop runs wide bandwidth while acquiring and narrows once locked, except with a bandwidth floor of four or five.
// - The output equals the timing clock times the current N handed out.
// - The modulator dithers the integer divide so its average is the fractional ratio.
// - In hybrid mode the loop corrects N so the timing clock does not set the output rate.
// - Each ratio is unsigned 32-bit with 12 integer and 20 fraction bits.
// - After lock the loop bandwidth settles to four plus the bandwidth floor, wrapping in three bits.
module fracn_ratio_mode_select #(
  parameter int REF_LOSS_CYCLES = fracn_pkg::REF_LOSS_CYC
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // pins
  input  wire logic [1:0]  MODE_SEL,
  input  wire logic        FREQ_REF_IN,
  input  wire logic        PLL_OUT_IN,
  // synthesizer side
  output logic [31:0]      FRAC_N,
  output logic             DIV_PLUS1,
  output logic             HYBRID_ACTIVE,
  output logic             LOCKED,
  output logic [2:0]       LOOP_BW
);

  typedef struct packed {
    logic [3:0][31:0]          user_ratio;
    fracn_pkg::global_cfg_s    gcfg;
    logic [2:0][1:0]           mode_sync;
    logic [1:0]                mode;
    logic [2:0]                ref_sync;
    logic [2:0]                out_sync;
    logic [31:0]               ref_gap;
    logic                      ref_present;
    logic [31:0]               out_cnt;
    logic [31:0]               meas;
    logic [31:0]               n;
    logic [31:0]               acc;
    logic                      carry;
    fracn_pkg::loop_state_e    st;
    logic [3:0]                hold;
    logic [2:0]                bw;
    logic                      wr_pend;
    logic [7:0]                wr_addr;
    logic [31:0]               rdata;
  } state_s;

  state_s s_r, s_nxt;

  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : is_ofs

  logic        ref_rise, out_rise, addr_ok, hybrid;
  logic [31:0] target, err, abs_err, step, rd_val;

  always_comb begin
    s_nxt     = s_r;
    ref_rise  = s_r.ref_sync[1] & ~s_r.ref_sync[2];
    out_rise  = s_r.out_sync[1] & ~s_r.out_sync[2];
    addr_ok   = HSEL & HREADY & HTRANS[1];
    // pins pass three flops; a change counts when stages two and three agree
    s_nxt.mode_sync = {s_r.mode_sync[1:0], MODE_SEL};
    if (s_r.mode_sync[1] == s_r.mode_sync[2]) begin
      s_nxt.mode = s_r.mode_sync[2];
    end
    s_nxt.ref_sync = {s_r.ref_sync[1:0], FREQ_REF_IN};
    s_nxt.out_sync = {s_r.out_sync[1:0], PLL_OUT_IN};
    target = s_r.user_ratio[s_r.mode];
    // reference presence: lost after a long gap with no edge
    if (ref_rise) begin
      s_nxt.ref_gap     = 32'h0;
      s_nxt.ref_present = 1'b1;
    end else if (s_r.ref_gap >= 32'(REF_LOSS_CYCLES)) begin
      s_nxt.ref_present = 1'b0;
    end else begin
      s_nxt.ref_gap = s_r.ref_gap + 32'h1;
    end
    // auto follows reference presence, manual follows the global hybrid bit
    hybrid = s_r.gcfg.auto_select ? s_r.ref_present : s_r.gcfg.manual_hybrid;
    // output edges per reference period, scaled to 12.20
    if (ref_rise) begin
      s_nxt.meas    = {s_r.out_cnt[11:0], 20'h0};
      s_nxt.out_cnt = 32'(out_rise);
    end else begin
      s_nxt.out_cnt = s_r.out_cnt + 32'(out_rise);
    end
    err     = target - s_r.meas;
    abs_err = err[31] ? (32'h0 - err) : err;
    step    = $signed(err) >>> s_r.bw;
    step    = (ref_rise && s_r.st != fracn_pkg::ST_STATIC) ? step : 32'h0;
    case (s_r.st)
      fracn_pkg::ST_STATIC: begin
        s_nxt.n  = target;
        s_nxt.bw = fracn_pkg::BW_WIDE;
        if (hybrid) begin
          s_nxt.st   = fracn_pkg::ST_ACQUIRE;
          s_nxt.hold = 4'h0;
        end
      end
      fracn_pkg::ST_ACQUIRE: begin
        s_nxt.n  = s_r.n + step;
        s_nxt.bw = 3'h1;
        if (!hybrid) begin
          s_nxt.st = fracn_pkg::ST_STATIC;
        end else if (ref_rise) begin
          if (abs_err[31:20] == 12'h0 && abs_err[19:0] < 20'(fracn_pkg::LOCK_TOL << 12)) begin
            s_nxt.hold = s_r.hold + 4'h1;
          end else begin
            s_nxt.hold = 4'h0;
          end
          if (s_r.hold >= 4'(fracn_pkg::LOCK_HOLD)) begin
            s_nxt.st = fracn_pkg::ST_LOCKED;
          end
        end
      end
      fracn_pkg::ST_LOCKED: begin
        s_nxt.n  = s_r.n + step;
        s_nxt.bw = 3'h4 + s_r.gcfg.loop_bandwidth_floor;
        if (!hybrid) begin
          s_nxt.st = fracn_pkg::ST_STATIC;
        end
      end
      default: begin
        s_nxt.st = fracn_pkg::ST_STATIC;
      end
    endcase
    // first-order modulator: fraction accumulates, carry adds one to the integer divide
    {s_nxt.carry, s_nxt.acc[19:0]} = {1'b0, s_r.acc[19:0]} + {1'b0, s_r.n[19:0]};
    s_nxt.acc[31:20] = 12'h0;
    // ahb write data phase
    s_nxt.wr_pend = addr_ok & HWRITE;
    s_nxt.wr_addr = HADDR;
    if (s_r.wr_pend) begin
      if (is_ofs(s_r.wr_addr, fracn_pkg::OFS_RATIO0)) begin
        s_nxt.user_ratio[0] = HWDATA;
      end else if (is_ofs(s_r.wr_addr, fracn_pkg::OFS_RATIO1)) begin
        s_nxt.user_ratio[1] = HWDATA;
      end else if (is_ofs(s_r.wr_addr, fracn_pkg::OFS_RATIO2)) begin
        s_nxt.user_ratio[2] = HWDATA;
      end else if (is_ofs(s_r.wr_addr, fracn_pkg::OFS_RATIO3)) begin
        s_nxt.user_ratio[3] = HWDATA;
      end else if (is_ofs(s_r.wr_addr, fracn_pkg::OFS_GLOBAL)) begin
        s_nxt.gcfg.loop_bandwidth_floor = HWDATA[fracn_pkg::GL_BW_LSB +: 3];
        s_nxt.gcfg.auto_select          = HWDATA[fracn_pkg::GL_AUTO_BIT];
        s_nxt.gcfg.manual_hybrid        = HWDATA[fracn_pkg::GL_HYB_BIT];
      end
    end
    // ahb read: decode in address phase, data registered
    rd_val = 32'h0;
    if (HADDR[7:4] == 4'h0) begin
      rd_val = s_r.user_ratio[HADDR[3:2]];
    end else if (is_ofs(HADDR, fracn_pkg::OFS_GLOBAL)) begin
      rd_val = {26'h0, s_r.gcfg.manual_hybrid, s_r.gcfg.auto_select, 1'b0,
                s_r.gcfg.loop_bandwidth_floor};
    end else if (is_ofs(HADDR, fracn_pkg::OFS_STATUS)) begin
      rd_val = {22'h0, s_r.bw, s_r.st, s_r.mode, s_r.ref_present, hybrid,
                s_r.st == fracn_pkg::ST_LOCKED};
    end else if (is_ofs(HADDR, fracn_pkg::OFS_N)) begin
      rd_val = s_r.n;
    end else if (is_ofs(HADDR, fracn_pkg::OFS_MEAS)) begin
      rd_val = s_r.meas;
    end
    if (addr_ok & ~HWRITE) begin
      s_nxt.rdata = rd_val;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_r            <= '0;
      s_r.user_ratio <= {4{fracn_pkg::RATIO_RST}};
      s_r.gcfg       <= '{fracn_pkg::BW_RST, 1'b1, 1'b0};
      s_r.n          <= fracn_pkg::RATIO_RST;
      s_r.bw         <= fracn_pkg::BW_WIDE;
      s_r.st         <= fracn_pkg::ST_STATIC;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs; n is a registered value so the synthesizer never sees a half update
  assign FRAC_N        = s_r.n;
  assign DIV_PLUS1     = s_r.carry;
  assign HYBRID_ACTIVE = s_r.st != fracn_pkg::ST_STATIC;
  assign LOCKED        = s_r.st == fracn_pkg::ST_LOCKED;
  assign LOOP_BW       = s_r.bw;
  assign HRDATA        = s_r.rdata;
  assign HREADYOUT     = 1'b1;
  assign HRESP         = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_mode_stable;
    @(posedge REF_CLK) disable iff (RST)
      (s_r.mode_sync[1] != s_r.mode_sync[2]) |=> $stable(s_r.mode);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode moved on disagreement");

  property p_static_n;
    @(posedge REF_CLK) disable iff (RST)
      (s_r.st == fracn_pkg::ST_STATIC) |=> (FRAC_N == $past(target));
  endproperty
  a_static_n: assert property (p_static_n) else $error("static n not target");

  property p_global_fixed;
    @(posedge REF_CLK) disable iff (RST)
      (!s_r.wr_pend) |=> $stable(s_r.gcfg);
  endproperty
  a_global_fixed: assert property (p_global_fixed) else $error("global moved");

  property p_lock_bw;
    @(posedge REF_CLK) disable iff (RST)
      LOCKED ##1 LOCKED |-> LOOP_BW == 3'(3'h4 + $past(s_r.gcfg.loop_bandwidth_floor));
  endproperty
  a_lock_bw: assert property (p_lock_bw) else $error("locked bw wrong");

  property p_acq_wide;
    @(posedge REF_CLK) disable iff (RST)
      (s_r.st == fracn_pkg::ST_ACQUIRE) ##1 (s_r.st == fracn_pkg::ST_ACQUIRE) |-> LOOP_BW == 3'h1;
  endproperty
  a_acq_wide: assert property (p_acq_wide) else $error("acquire bw not wide");

  property p_auto_drop;
    @(posedge REF_CLK) disable iff (RST)
      (s_r.gcfg.auto_select && !s_r.ref_present && HYBRID_ACTIVE) |=> !HYBRID_ACTIVE;
  endproperty
  a_auto_drop: assert property (p_auto_drop) else $error("hybrid kept without ref");

  property p_target_sel;
    @(posedge REF_CLK) disable iff (RST)
      (s_r.mode_sync[1] == s_r.mode_sync[2]) |=> (s_r.mode == $past(s_r.mode_sync[2]));
  endproperty
  a_target_sel: assert property (p_target_sel) else $error("wrong ratio set");

  property p_carry;
    @(posedge REF_CLK) disable iff (RST)
      (FRAC_N[19:0] == 20'h0) ##1 $stable(FRAC_N) |-> !DIV_PLUS1;
  endproperty
  a_carry: assert property (p_carry) else $error("carry with zero fraction");

  c_lock:   cover property (@(posedge REF_CLK) disable iff (RST) $rose(LOCKED));
  c_hybrid: cover property (@(posedge REF_CLK) disable iff (RST) $rose(HYBRID_ACTIVE));
  c_mode:   cover property (@(posedge REF_CLK) disable iff (RST) s_r.mode == 2'h3);

endmodule : fracn_ratio_mode_select

`default_nettype wire

// [fracn_ref_model.sv]
// fracn_ref_model: frequency reference clock and fed-back output clock for the selector bench
// assumes the bench gates the reference; both clocks toggle on fixed delays of their own, not off the core clock
`timescale 1ns/1ps
`default_nettype none
module fracn_ref_model #(
  parameter int REF_HALF_NS = 800,
  parameter int OUT_HALF_NS = 200
) (
  // control
  input  wire logic ref_en,
  // clocks
  output logic      freq_ref,
  output logic      pll_out
);
  initial begin
    freq_ref = 1'b0;
    pll_out  = 1'b0;
  end
  // output clock runs free; ratio to the reference is fixed at four, no vco behind it
  always #(OUT_HALF_NS) pll_out = ~pll_out;
  // reference stands still low while absent, so loss detection really sees no edges
  always begin
    #(REF_HALF_NS);
    freq_ref = ref_en ? ~freq_ref : 1'b0;
  end
endmodule : fracn_ref_model
`default_nettype wire

// [fracn_ratio_mode_select_tb_top.sv]
// fracn_ratio_mode_select_tb_top: self-checking bench for the ratio mode selector
// assumes a zero-wait ahb slave and the clock pair of fracn_ref_model
`timescale 1ns/1ps
`default_nettype none
module fracn_ratio_mode_select_tb_top;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              hsel = 1'b0;
  logic [7:0]        haddr = 8'h00;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = 32'h0;
  logic [1:0]        mode_sel = 2'h0;
  logic              ref_en = 1'b0;
  logic [31:0]       seed = 32'hcf12;
  logic [31:0]       ratio [4];
  logic [31:0]       rd;
  logic [31:0]       prev;
  wire  logic        freq_ref, pll_out, hreadyout, hresp, div_plus1, hybrid, locked;
  wire  logic [31:0] hrdata, frac_n;
  wire  logic [2:0]  loop_bw;
  int                n_errors = 0;
  int                comparisons = 0;
  int                cnt;
  always #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  fracn_ref_model i_ref (.ref_en(ref_en), .freq_ref(freq_ref), .pll_out(pll_out));
  // loss span above one reference period (80 cycles) but short enough for a quick fallback
  fracn_ratio_mode_select #(.REF_LOSS_CYCLES(200)) i_dut (
    .REF_CLK(ref_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .MODE_SEL(mode_sel), .FREQ_REF_IN(freq_ref),
    .PLL_OUT_IN(pll_out), .FRAC_N(frac_n), .DIV_PLUS1(div_plus1),
    .HYBRID_ACTIVE(hybrid), .LOCKED(locked), .LOOP_BW(loop_bw));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  function automatic logic [31:0] exp_bw(input logic [2:0] floor_v);
    return 32'(floor_v) + 32'h4;
  endfunction : exp_bw
  function automatic logic [31:0] exp_carry(input logic [31:0] r, input int n);
    return (32'(r[19:0]) * 32'(n)) >> 20;
  endfunction : exp_carry
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one single-word transfer; waits on ready in both phases, read data taken at the end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask : bus
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wrap_up();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400_000;
    n_errors++;
    wrap_up();
  end
  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    chk(frac_n, 32'h0010_0000);
    chk({30'h0, hybrid, locked}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0010_0000);
      chk({31'h0, hresp}, 32'h0);
      ratio[i] = xorshift();
      bus(1'b1, 8'(4 * i), ratio[i]);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk(rd, ratio[i]);
    end
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // walk every code, ending back on zero; old set must stand until sync completes
    for (int k = 1; k <= 4; k++) begin
      prev = frac_n;
      @(posedge ref_clk);
      mode_sel <= 2'(k);
      cyc(4);
      chk(frac_n, prev);
      cyc(6);
      chk(frac_n, ratio[k % 4]);
      bus(1'b0, 8'h14, 32'h0);
      chk({30'h0, rd[4:3]}, 32'(k % 4));
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h10);
    end
    bus(1'b1, 8'h00, 32'h0014_0000);
    cyc(4);
    chk(frac_n, 32'h0014_0000);
    cnt = 0;
    repeat (64) begin
      @(posedge ref_clk);
      cnt += int'(div_plus1);
    end
    chk(32'(cnt), exp_carry(32'h0014_0000, 64));
    // manual hybrid, floor two, target ratio four
    bus(1'b1, 8'h00, 32'h0040_0000);
    bus(1'b1, 8'h10, 32'h22);
    cyc(4);
    chk({31'h0, hybrid}, 32'h1);
    chk({29'h0, loop_bw}, 32'h1);
    ref_en <= 1'b1;
    for (cnt = 0; cnt < 4000 && locked !== 1'b1; cnt++) @(posedge ref_clk);
    // narrow gain lands one cycle after the lock state
    cyc(2);
    chk({31'h0, locked}, 32'h1);
    chk({29'h0, loop_bw}, exp_bw(3'h2));
    bus(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0040_0000);
    // automatic selection follows reference presence
    bus(1'b1, 8'h10, 32'h12);
    cyc(4);
    chk({31'h0, hybrid}, 32'h1);
    ref_en <= 1'b0;
    cyc(300);
    chk({30'h0, hybrid, locked}, 32'h0);
    chk(frac_n, 32'h0040_0000);
    wrap_up();
  end
endmodule : fracn_ratio_mode_select_tb_top
`default_nettype wire
